/* File: core/iod_regs.vh */
// Constants for the I/O space access decoder: ops, address ranges, map, masks
`ifndef IOD_REGS_VH
`define IOD_REGS_VH

// ----------------------------------------------------------------------------
// Core operation codes
// ----------------------------------------------------------------------------
`define IOD_OP_PORT_LOAD   3'h0
`define IOD_OP_PORT_STORE  3'h1
`define IOD_OP_BIT_SET     3'h2
`define IOD_OP_BIT_CLEAR   3'h3
`define IOD_OP_SKIP_HIGH   3'h4
`define IOD_OP_SKIP_LOW    3'h5
`define IOD_OP_MEM_FETCH   3'h6
`define IOD_OP_MEM_PUT     3'h7

// ----------------------------------------------------------------------------
// Address ranges (I/O addresses, data-space addresses)
// ----------------------------------------------------------------------------
`define IOD_BIT_IO_LAST    8'h1F
`define IOD_PORT_IO_LAST   8'h3F
`define IOD_IO_DATA_OFS    8'h20
`define IOD_EXT_FIRST      8'h60
`define IOD_EXT_LAST       8'hFF
`define IOD_IO_DEPTH       64
`define IOD_EXT_DEPTH      16

// ----------------------------------------------------------------------------
// Write-one-to-clear flag register (I/O address)
// ----------------------------------------------------------------------------
`define IOD_FLAG_IO        6'h16

// ----------------------------------------------------------------------------
// Extended register map (data-space offsets) and writable-bit masks
// ----------------------------------------------------------------------------
`define IOD_EXT_BASE       8'hB0
`define IOD_TIMER2_CONTROL_A      8'hB0
`define IOD_TIMER2_CONTROL_B      8'hB1
`define IOD_TIMER2_COUNT          8'hB2
`define IOD_TIMER2_COMPARE_A      8'hB3
`define IOD_TIMER2_COMPARE_B      8'hB4
`define IOD_ASYNC_TIMER_STATUS    8'hB6
`define IOD_TWOWIRE_BIT_RATE      8'hB8
`define IOD_TWOWIRE_STATUS        8'hB9
`define IOD_TWOWIRE_OWN_ADDRESS   8'hBA
`define IOD_TWOWIRE_DATA          8'hBB
`define IOD_TWOWIRE_CONTROL       8'hBC
`define IOD_TWOWIRE_ADDRESS_MASK  8'hBD

`define IOD_MASK_TIMER2_CONTROL_A     8'hF3
`define IOD_MASK_TIMER2_CONTROL_B     8'hCF
`define IOD_MASK_FULL                 8'hFF
`define IOD_MASK_ASYNC_TIMER_STATUS   8'h7F
`define IOD_MASK_TWOWIRE_STATUS       8'hFB
`define IOD_MASK_TWOWIRE_CONTROL      8'hFD
`define IOD_MASK_TWOWIRE_ADDRESS_MASK 8'hFE
`define IOD_MASK_NONE                 8'h00
`define IOD_RESET_VALUE               8'h00

`endif

/* File: core/iod_io_space_decoder.v */
// I/O space access decoder: port, bit and data-space access to peripheral registers
//
// Functional notes
// - Bit set and clear reach only I/O addresses 0x00 to 0x1F.
// - In that range, skip-when-high/low test one bit and report skip.
// - Flag bits clear when software writes a one to them.
// - Bit set/clear changes only the addressed bit, never clears other flags.
// - Port load/store use a six-bit I/O address, locations 0x00 to 0x3F.
// - Data-space address of an I/O register is its I/O address plus 0x20.
// - Extended locations 0x60 to 0xFF only via data-space fetch and put.
`timescale 1ns/1ps
`default_nettype none
`include "iod_regs.vh"

module iod_io_space_decoder (
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  input  wire        req,
  input  wire [2:0]  op,
  input  wire [7:0]  addr,
  input  wire [2:0]  bit_sel,
  input  wire [7:0]  wdata,
  input  wire [7:0]  flag_set,
  output reg         ack_r,
  output reg         reject_r,
  output reg         skip_r,
  output reg  [7:0]  rdata_r,
  output reg  [7:0]  flag_r,
  output reg  [7:0]  timer2_control_a_r,
  output reg  [7:0]  twowire_control_r
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg [7:0] io_mem [0:`IOD_IO_DEPTH-1];
  reg [7:0] ext_mem [0:`IOD_EXT_DEPTH-1];

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  reg        port_op;
  reg        bit_op;
  reg        legal;
  reg        is_io;
  reg        is_flag;
  reg        wr_op;
  reg  [7:0] daddr;
  reg  [7:0] io_off;
  reg  [5:0] io_idx;
  reg  [3:0] ext_idx;
  reg  [7:0] mask;
  reg  [7:0] cur;
  reg  [7:0] bit_onehot;
  reg  [7:0] wv;
  reg  [7:0] clr_pat;
  wire [7:0] flag_nxt;

  // Writable bits of each extended location; zero marks a reserved location
  function [7:0] ext_mask;
    input [7:0] a;
    begin
      case (a)
        `IOD_TIMER2_CONTROL_A:     ext_mask = `IOD_MASK_TIMER2_CONTROL_A;
        `IOD_TIMER2_CONTROL_B:     ext_mask = `IOD_MASK_TIMER2_CONTROL_B;
        `IOD_TIMER2_COUNT:         ext_mask = `IOD_MASK_FULL;
        `IOD_TIMER2_COMPARE_A:     ext_mask = `IOD_MASK_FULL;
        `IOD_TIMER2_COMPARE_B:     ext_mask = `IOD_MASK_FULL;
        `IOD_ASYNC_TIMER_STATUS:   ext_mask = `IOD_MASK_ASYNC_TIMER_STATUS;
        `IOD_TWOWIRE_BIT_RATE:     ext_mask = `IOD_MASK_FULL;
        `IOD_TWOWIRE_STATUS:       ext_mask = `IOD_MASK_TWOWIRE_STATUS;
        `IOD_TWOWIRE_OWN_ADDRESS:  ext_mask = `IOD_MASK_FULL;
        `IOD_TWOWIRE_DATA:         ext_mask = `IOD_MASK_FULL;
        `IOD_TWOWIRE_CONTROL:      ext_mask = `IOD_MASK_TWOWIRE_CONTROL;
        `IOD_TWOWIRE_ADDRESS_MASK: ext_mask = `IOD_MASK_TWOWIRE_ADDRESS_MASK;
        default:                   ext_mask = `IOD_MASK_NONE;
      endcase
    end
  endfunction

  always @* begin
    port_op = (op == `IOD_OP_PORT_LOAD) || (op == `IOD_OP_PORT_STORE);
    bit_op  = (op == `IOD_OP_BIT_SET) || (op == `IOD_OP_BIT_CLEAR) ||
              (op == `IOD_OP_SKIP_HIGH) || (op == `IOD_OP_SKIP_LOW);
    wr_op   = (op == `IOD_OP_PORT_STORE) || (op == `IOD_OP_MEM_PUT) ||
              (op == `IOD_OP_BIT_SET) || (op == `IOD_OP_BIT_CLEAR);
    if (port_op) begin
      daddr = {2'b00, addr[5:0]} + `IOD_IO_DATA_OFS;
      legal = (addr <= `IOD_PORT_IO_LAST);
    end else if (bit_op) begin
      daddr = {3'b000, addr[4:0]} + `IOD_IO_DATA_OFS;
      legal = (addr <= `IOD_BIT_IO_LAST);
    end else begin
      // Below the offset lies the register file, which this block does not own
      daddr = addr;
      legal = (addr >= `IOD_IO_DATA_OFS);
    end
    is_io   = (daddr < `IOD_EXT_FIRST);
    io_off  = daddr - `IOD_IO_DATA_OFS;
    io_idx  = io_off[5:0];
    ext_idx = daddr[3:0];
    mask    = is_io ? `IOD_MASK_FULL : ext_mask(daddr);
    is_flag = is_io && (io_idx == `IOD_FLAG_IO);
    if (is_flag) begin
      cur = flag_r;
    end else if (is_io) begin
      cur = io_mem[io_idx];
    end else begin
      cur = ext_mem[ext_idx] & mask;
    end
    bit_onehot = 8'h01 << bit_sel;
    case (op)
      `IOD_OP_BIT_SET: begin
        wv      = cur | bit_onehot;
        clr_pat = bit_onehot;
      end
      `IOD_OP_BIT_CLEAR: begin
        wv      = cur & ~bit_onehot;
        clr_pat = 8'h00;
      end
      default: begin
        wv      = wdata;
        clr_pat = wdata;
      end
    endcase
  end

  // Hardware set wins over a same-cycle write-one clear
  assign flag_nxt = (flag_r & ~((req && legal && wr_op && is_flag) ? clr_pat : 8'h00))
                    | flag_set;

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  // Storage only moves for a legal request on an enabled edge
  wire take   = ce && req;
  wire io_we  = take && legal && wr_op && is_io && !is_flag;
  wire ext_we = take && legal && wr_op && !is_io;

  // --------------------------------------------------------------------------
  // Response to the core
  // --------------------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_r    <= 1'b0;
      reject_r <= 1'b0;
      skip_r   <= 1'b0;
      rdata_r  <= `IOD_RESET_VALUE;
    end else if (ce) begin
      ack_r    <= req;
      reject_r <= req && !legal;
      skip_r   <= 1'b0;
      if (req && legal) begin
        rdata_r <= cur;
        if (op == `IOD_OP_SKIP_HIGH) begin
          skip_r <= cur[bit_sel];
        end
        if (op == `IOD_OP_SKIP_LOW) begin
          skip_r <= !cur[bit_sel];
        end
      end else if (req) begin
        // A refused access reads zero so that no stale value looks valid
        rdata_r <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Write-one-to-clear flags
  // --------------------------------------------------------------------------
  // The enable also gates capture of hardware events
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_r <= `IOD_RESET_VALUE;
    end else if (ce) begin
      flag_r <= flag_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // I/O and extended storage
  // --------------------------------------------------------------------------
  integer i;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < `IOD_IO_DEPTH; i = i + 1) begin
        io_mem[i] <= `IOD_RESET_VALUE;
      end
      for (i = 0; i < `IOD_EXT_DEPTH; i = i + 1) begin
        ext_mem[i] <= `IOD_RESET_VALUE;
      end
    end else begin
      if (io_we) begin
        io_mem[io_idx] <= wv;
      end
      if (ext_we) begin
        // Reserved bits and locations keep zero whatever is written
        ext_mem[ext_idx] <= (wv & mask) | (ext_mem[ext_idx] & ~mask);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control copies handed to the timer and two-wire blocks
  // --------------------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      timer2_control_a_r <= `IOD_RESET_VALUE;
      twowire_control_r  <= `IOD_RESET_VALUE;
    end else if (ext_we) begin
      if (daddr == `IOD_TIMER2_CONTROL_A) begin
        timer2_control_a_r <= wv & mask;
      end
      if (daddr == `IOD_TWOWIRE_CONTROL) begin
        twowire_control_r <= wv & mask;
      end
    end
  end

endmodule
`default_nettype wire

/* File: verif/iod_sva.sv */
// Assertion checker for the I/O space access decoder
`timescale 1ns/1ps
`default_nettype none
`include "iod_regs.vh"
module iod_sva (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       ce,
  input wire logic       req,
  input wire logic       ack_r,
  input wire logic       reject_r,
  input wire logic       skip_r,
  input wire logic [2:0] op,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] flag_set,
  input wire logic [7:0] rdata_r,
  input wire logic [7:0] flag_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire tk = ce && req;
  // Flag accesses only count when no hardware event competes in the same cycle
  wire fl = tk && addr == 8'h16 && flag_set == 8'h00;
  property p_ack; tk |=> ack_r; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_bit; tk && op[2:1] == 2'b01 && addr > 8'h1F |=> reject_r; endproperty
  a_bit: assert property (p_bit) else $error("bit op out of range");
  property p_port; tk && op[2:1] == 2'b00 && addr > 8'h3F |=> reject_r; endproperty
  a_port: assert property (p_port) else $error("port op out of range");
  property p_mem; tk && op[2:1] == 2'b11 && addr < 8'h20 |=> reject_r; endproperty
  a_mem: assert property (p_mem) else $error("data op below offset");
  property p_rej; reject_r |-> ack_r && rdata_r == 8'h00; endproperty
  a_rej: assert property (p_rej) else $error("refused access data");
  property p_skip;
    skip_r |-> ack_r && $past(op[2:1]) == 2'b10 && $past(addr) < 8'h20; endproperty
  a_skip: assert property (p_skip) else $error("skip without test");
  property p_w1c;
    fl && op == `IOD_OP_PORT_STORE |=> flag_r == ($past(flag_r) & ~$past(wdata)); endproperty
  a_w1c: assert property (p_w1c) else $error("flag write one clear");
  property p_bclr; fl && op == `IOD_OP_BIT_CLEAR |=> $stable(flag_r); endproperty
  a_bclr: assert property (p_bclr) else $error("flag disturbed");
  c_skip: cover property (skip_r);
  c_rej: cover property (reject_r);
  c_b2b: cover property (ack_r [*2]);
endmodule
bind iod_io_space_decoder iod_sva iod_sva_i (.clk(clk), .reset(reset), .ce(ce), .req(req),
  .ack_r(ack_r), .reject_r(reject_r), .skip_r(skip_r), .op(op), .addr(addr), .wdata(wdata),
  .flag_set(flag_set), .rdata_r(rdata_r), .flag_r(flag_r));
`default_nettype wire

/* File: verif/iod_core_model.sv */
// Processor core model issuing I/O and data-space requests
`timescale 1ns/1ps
`default_nettype none
module iod_core_model (
  input  wire logic       clk,
  output var  logic       req,
  output var  logic [2:0] op,
  output var  logic [2:0] bit_sel,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata
);
  initial {req, op, bit_sel, addr, wdata} = '0;
  // Launched on the falling edge so the decoder samples a settled request
  task automatic go(input logic [2:0] o, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] d);
    {req, op, addr, bit_sel, wdata} <= {1'b1, o, a, b, d};
    @(negedge clk);
  endtask
  task automatic stop();
    req <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/io_space_access_decoder_tb_top.sv */
// Self-checking bench for the I/O space access decoder
`timescale 1ns/1ps
`default_nettype none
`include "iod_regs.vh"
module io_space_access_decoder_tb_top;
  logic clk = 0, reset = 1, ce = 1;
  logic [7:0] flag_set = 8'h00, d;
  wire logic req, ack_r, reject_r, skip_r;
  wire logic [2:0] op, bit_sel;
  wire logic [7:0] addr, wdata, rdata_r, flag_r, timer2_control_a_r, twowire_control_r;
  int err_count = 0, checks_done = 0;
  logic [10:0] notes[$], e;
  localparam logic [7:0] xa [5] = '{8'hB0, 8'hBC, 8'hB5, 8'h70, 8'hB2};
  localparam logic [7:0] xm [5] = '{8'hF3, 8'hFD, 8'h00, 8'h00, 8'hFF};
  always #4 clk = ~clk;
  iod_core_model iod_core_model_i (.clk(clk), .req(req), .op(op), .bit_sel(bit_sel),
    .addr(addr), .wdata(wdata));
  iod_io_space_decoder iod_io_space_decoder_i (.clk(clk), .reset(reset), .ce(ce), .req(req),
    .op(op), .addr(addr), .bit_sel(bit_sel), .wdata(wdata), .flag_set(flag_set),
    .ack_r(ack_r), .reject_r(reject_r), .skip_r(skip_r), .rdata_r(rdata_r), .flag_r(flag_r),
    .timer2_control_a_r(timer2_control_a_r), .twowire_control_r(twowire_control_r));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  // Note layout: {read data checked, refused, skip, read data}
  task automatic acc(input logic [2:0] o, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] dd, input logic [10:0] x);
    notes.push_back(x);
    iod_core_model_i.go(o, a, b, dd);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (ack_r === 1'b1) begin
      e = notes.size() > 0 ? notes.pop_front() : 11'h7FF;
      chk("status", {6'h00, reject_r, skip_r}, {6'h00, e[9:8]});
      if (e[10]) chk("rdata", rdata_r, e[7:0]);
    end
  end
  initial begin
    void'($urandom(11));
    repeat (2) @(negedge clk);
    reset = 0;
    for (int i = 0; i < 8; i++)
      acc(i[2:0], i < 2 ? 8'h40 : i < 6 ? 8'h20 : 8'h1F, 3'h0, 8'hFF, 11'h600);
    for (int i = 0; i < 64; i++) begin
      if (i == 22) continue;
      d = 8'($urandom);
      acc(`IOD_OP_PORT_STORE, i[7:0], 3'h0, d, 11'h000);
      acc(`IOD_OP_MEM_FETCH, i[7:0] + 8'h20, 3'h0, 8'h00, {3'b100, d});
    end
    acc(`IOD_OP_MEM_PUT, 8'h25, 3'h0, 8'h5A, 11'h000);
    acc(`IOD_OP_BIT_SET, 8'h05, 3'h0, 8'h00, 11'h000);
    acc(`IOD_OP_BIT_CLEAR, 8'h05, 3'h6, 8'h00, 11'h000);
    acc(`IOD_OP_SKIP_HIGH, 8'h05, 3'h1, 8'h00, 11'h100);
    acc(`IOD_OP_SKIP_LOW, 8'h05, 3'h1, 8'h00, 11'h000);
    acc(`IOD_OP_SKIP_LOW, 8'h05, 3'h2, 8'h00, 11'h100);
    acc(`IOD_OP_PORT_LOAD, 8'h05, 3'h0, 8'h00, 11'h41B);
    iod_core_model_i.stop();
    flag_set = 8'hFF;
    @(negedge clk);
    flag_set = 8'h00;
    acc(`IOD_OP_BIT_CLEAR, 8'h16, 3'h3, 8'h00, 11'h000);
    acc(`IOD_OP_BIT_SET, 8'h16, 3'h2, 8'h00, 11'h000);
    acc(`IOD_OP_PORT_STORE, 8'h16, 3'h0, 8'h81, 11'h000);
    acc(`IOD_OP_PORT_LOAD, 8'h16, 3'h0, 8'h00, 11'h47A);
    // With the enable low neither a request nor a flag event may leave a trace
    iod_core_model_i.stop();
    @(negedge clk);
    ce = 1'b0;
    flag_set = 8'h80;
    iod_core_model_i.go(`IOD_OP_PORT_STORE, 8'h05, 3'h0, 8'h00);
    ce = 1'b1;
    flag_set = 8'h00;
    acc(`IOD_OP_PORT_LOAD, 8'h05, 3'h0, 8'h00, 11'h41B);
    for (int i = 0; i < 5; i++) begin
      // Reserved locations are only read, and reserved bits are written as zero
      if (xm[i] != 8'h00)
        acc(`IOD_OP_MEM_PUT, xa[i], 3'h0, xm[i], 11'h000);
      else
        acc(`IOD_OP_MEM_FETCH, xa[i], 3'h0, 8'h00, 11'h400);
      acc(`IOD_OP_MEM_FETCH, xa[i], 3'h0, 8'h00, {3'b100, xm[i]});
    end
    iod_core_model_i.stop();
    for (int k = 0; k < 8 && notes.size() > 0; k++) @(negedge clk);
    chk("pending", 8'(notes.size()), 8'h00);
    chk("flag", flag_r, 8'h7A);
    chk("timer", timer2_control_a_r, 8'hF3);
    chk("twowire", twowire_control_r, 8'hFD);
    conclude();
  end
endmodule
`default_nettype wire
